// >>> sim/illc_far_side_model.sv
// far side model: memory box answer and dispatch ram read data
`timescale 1ns/1ps
module illc_far_side_model (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic memory_cycle_start,
   input wire logic [3:0] resp_delay, // cycles from start to answer
   output logic memory_box_transfer,
   output logic [14:0] dispatch_ram_data
);
   logic [3:0] wait_r; // cycles left before the answer
   logic busy_r; // a started cycle awaits its answer
   // one answer per started cycle; a new start restarts the count
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         wait_r <= 4'h0;
         busy_r <= 1'b0;
         memory_box_transfer <= 1'b0;
      end
      else
      begin
         memory_box_transfer <= 1'b0;
         if (memory_cycle_start)
         begin
            busy_r <= 1'b1;
            wait_r <= resp_delay;
         end
         else if (busy_r && wait_r <= 4'h1)
         begin
            busy_r <= 1'b0;
            memory_box_transfer <= 1'b1; // ends the cycle
         end
         else if (busy_r)
            wait_r <= wait_r - 4'h1;
      end
   end
   // data moves every cycle so a sample taken a cycle off shows
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         dispatch_ram_data <= 15'h0000;
      else
         dispatch_ram_data <= dispatch_ram_data + 15'h1235;
   end
endmodule

// >>> sim/test_instruction_latch_load_control.sv
// self-checking bench of the instruction latch load control
`timescale 1ns/1ps
module test_instruction_latch_load_control;
   import illc_pkg::*;
   logic clk;
   logic reset_n;
   logic [12:0] adder, cache, wreg, wext; // instruction sources
   logic sel, addr_ld, mc_start, box_xfer, fast_xfer, cond; // control lines
   illc_qual_t qual; // fetch is the upper bit
   logic [3:0] vaddr_low, delay, acf, fast_addr;
   logic [14:0] disp_data, dor, exp_dor; // dispatch data, register, expected
   logic [12:0] instr;
   logic drl;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
   logic [1:0] bresp, rresp;
   int num_errors = 0;
   int check_count = 0;
   illc_instruction_latch_load_control u_illc_instruction_latch_load_control (
      .clk(clk), .reset_n(reset_n), .adder_out(adder), .cache_data(cache), .work_register(wreg),
      .work_extension(wext), .memory_transfer_clock_select(sel), .request_qualifiers(qual),
      .address_load(addr_ld), .memory_cycle_start(mc_start), .memory_box_transfer(box_xfer),
      .fast_memory_transfer(fast_xfer), .virtual_address_low(vaddr_low), .load_instruction_condition(cond),
      .dispatch_ram_data(disp_data), .instruction_register(instr), .accumulator_field_reg(acf),
      .dispatch_output_reg(dor), .fast_memory_address(fast_addr), .dispatch_register_load(drl),
      .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready)
   );
   illc_far_side_model u_illc_far_side_model (
      .clk(clk), .reset_n(reset_n), .memory_cycle_start(mc_start), .resp_delay(delay),
      .memory_box_transfer(box_xfer), .dispatch_ram_data(disp_data)
   );
   // 100 ns clock
   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // compare, count, report at once
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp)
      begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   // one bus transfer; each channel held until its own ready
   task automatic axi(input logic we, input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      int n;
      @(posedge clk);
      awaddr <= a;
      araddr <= a;
      wdata <= d;
      awvalid <= we;
      wvalid <= we;
      bready <= we;
      arvalid <= !we;
      rready <= !we;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
         if (awready)
            awvalid <= 1'b0;
         if (wready)
            wvalid <= 1'b0;
         if (arready)
            arvalid <= 1'b0;
      end
      while (!(we ? bvalid : rvalid));
      // no local limit: only the watchdog ends a wait
      bready <= 1'b0;
      rready <= 1'b0;
      chk("answer_cycles", 32'h0000_0002, n); // taken at the first edge, answered the next
      chk("resp", er, we ? bresp : rresp);
      if (!we)
         chk("rdata", d, rdata);
   endtask
   // status word from read, fetch, cycle bits and instruction
   function automatic logic [31:0] stat(input logic [2:0] rfm, input logic [12:0] i);
      return {5'h00, rfm, 4'h0, i[3:0], 3'h0, i};
   endfunction
   // microcode condition load over the adder and cache mixer inputs, then hold
   task automatic t_cond();
      for (int s = 0; s < 2; s++)
      begin
         @(posedge clk);
         sel <= s[0];
         adder <= 13'h0a5c;
         cache <= 13'h1b37;
         vaddr_low <= 4'h9 + s[3:0];
         cond <= 1'b1;
         @(posedge clk);
         cond <= 1'b0;
         #1;
         exp_dor = disp_data;
         chk("instr", s ? 32'h0000_1b37 : 32'h0000_0a5c, instr); // one cycle load
         chk("acf", s ? 32'h0000_0007 : 32'h0000_000c, acf); // low field
         chk("fast_addr", 32'h0000_0009 + s, fast_addr); // address bits
         chk("drl", 32'h0000_0001, drl); // next clock
         @(posedge clk);
         #1;
         chk("dor", exp_dor, dor); // after the load closes
         chk("drl", 32'h0000_0000, drl); // single pulse
      end
      @(posedge clk);
      adder <= 13'h1fff;
      cache <= 13'h0000;
      repeat (3) @(posedge clk);
      #1;
      chk("instr", 32'h0000_1b37, instr); // held while shut
   endtask
   // diagnostic strobe from each source, above the cache choice
   task automatic t_strobe();
      for (int s = 0; s < 2; s++)
      begin
         @(posedge clk);
         wreg <= 13'h0123;
         wext <= 13'h1e0f;
         sel <= 1'b1;
         axi(1'b1, ILLC_OFS_CONTROL, s ? 32'h0000_0003 : 32'h0000_0001, ILLC_RESP_OKAY); // strobe
         @(posedge clk);
         #1;
         chk("instr", s ? 32'h0000_1e0f : 32'h0000_0123, instr); // strobe source
         axi(1'b0, ILLC_OFS_CONTROL, s ? 32'h0000_0002 : 32'h0000_0000, ILLC_RESP_OKAY); // pulse bit
      end
   endtask
   // fetch cycles: slow box answer, then a non-fetch cycle ended by fast memory
   task automatic t_fetch();
      @(posedge clk);
      delay <= 4'hc;
      sel <= 1'b0;
      adder <= 13'h0777;
      qual <= 2'h3;
      addr_ld <= 1'b1;
      mc_start <= 1'b1;
      @(posedge clk);
      addr_ld <= 1'b0;
      mc_start <= 1'b0;
      adder <= 13'h0888;
      @(posedge clk);
      #1;
      chk("instr", 32'h0000_0888, instr); // open in fetch cycle
      axi(1'b0, ILLC_OFS_STATUS, stat(3'h7, 13'h0888), ILLC_RESP_OKAY); // flags set
      repeat (14) @(posedge clk);
      axi(1'b0, ILLC_OFS_STATUS, stat(3'h6, 13'h0888), ILLC_RESP_OKAY); // box clears
      adder <= 13'h0999;
      repeat (3) @(posedge clk);
      #1;
      chk("instr", 32'h0000_0888, instr); // shut again
      @(posedge clk);
      delay <= 4'hf;
      qual <= 2'h1;
      addr_ld <= 1'b1;
      mc_start <= 1'b1;
      @(posedge clk);
      addr_ld <= 1'b0;
      mc_start <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      chk("instr", 32'h0000_0888, instr); // no fetch, stays shut
      axi(1'b0, ILLC_OFS_STATUS, stat(3'h5, 13'h0888), ILLC_RESP_OKAY); // new qualifiers
      fast_xfer <= 1'b1;
      @(posedge clk);
      fast_xfer <= 1'b0;
      axi(1'b0, ILLC_OFS_STATUS, stat(3'h4, 13'h0888), ILLC_RESP_OKAY); // fast clears
   endtask
   // refused and unmapped accesses, dispatch readback
   task automatic t_bus();
      axi(1'b1, ILLC_OFS_STATUS, 32'h0000_0001, ILLC_RESP_SLVERR);
      axi(1'b1, 8'h0c, 32'h0000_0001, ILLC_RESP_SLVERR);
      axi(1'b0, 8'h0c, 32'h0000_0000, ILLC_RESP_SLVERR);
      axi(1'b0, ILLC_OFS_DISPATCH, {17'h0_0000, exp_dor}, ILLC_RESP_OKAY); // readback
      #1;
      chk("instr", 32'h0000_0888, instr); // refused writes leave it
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // main sequence
   initial
   begin
      reset_n = 1'b0;
      {adder, cache, wreg, wext, exp_dor} = '0;
      {sel, addr_ld, mc_start, fast_xfer, cond, qual, vaddr_low, delay} = '0;
      {awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
      repeat (10) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      #1;
      chk("instr", 32'h0000_0000, instr); // reset value
      chk("dor", 32'h0000_0000, dor); // reset value
      axi(1'b0, ILLC_OFS_CONTROL, ILLC_CTL_RESET, ILLC_RESP_OKAY);
      t_cond();
      t_strobe();
      t_fetch();
      t_bus();
      report_and_stop();
   end
   // hang guard, far beyond the expected ninety or so cycles
   initial
   begin
      #400000;
      num_errors++;
      report_and_stop();
   end
endmodule

// >>> verilog/illc_gated_latch.sv
// enabled holding register standing in for a row of mixer latches
`timescale 1ns/1ps
module illc_gated_latch #(
   parameter int W = 13
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic open, // gate open: pass d
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   // latch modelled edge-wise: opens for the cycle, closes on the next clock edge
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         q <= '0;
      end
      else if (open)
      begin
         q <= d;
      end
   end
endmodule

// >>> verilog/illc_instruction_latch_load_control.sv
// instruction register load control with dispatch register follow-up and bus access
// Function
// - thirteen-bit instruction register holds or passes
// - mixer picks adder, or cache on transfer
// - latch gate from clock and load control
// - fetch and read qualifiers captured with address
// - memory cycle flag set, cleared by transfers
// - memory cycle during fetch opens register
// - microcode load condition opens the register
// - condition load completes in one cycle
// - diagnostic strobe loads work register contents
// - address bits 32-35 address fast memory
// - accumulator field and dispatch output registers
// - dispatch register loads the following clock
// - opens after one clock, closes next
//
// Our own choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
module illc_instruction_latch_load_control (
   input wire logic clk,
   input wire logic reset_n,
   // datapath and memory sources of the instruction
   input wire logic [illc_pkg::ILLC_INSTR_W-1:0] adder_out,
   input wire logic [illc_pkg::ILLC_INSTR_W-1:0] cache_data,
   input wire logic [illc_pkg::ILLC_INSTR_W-1:0] work_register,
   input wire logic [illc_pkg::ILLC_INSTR_W-1:0] work_extension,
   input wire logic memory_transfer_clock_select,
   // memory control
   input wire illc_pkg::illc_qual_t request_qualifiers,
   input wire logic address_load,
   input wire logic memory_cycle_start,
   input wire logic memory_box_transfer,
   input wire logic fast_memory_transfer,
   input wire logic [illc_pkg::ILLC_FMA_W-1:0] virtual_address_low,
   // microinstruction condition
   input wire logic load_instruction_condition,
   // dispatch ram read data
   input wire logic [illc_pkg::ILLC_DISP_W-1:0] dispatch_ram_data,
   // outputs toward datapath and dispatch ram
   output logic [illc_pkg::ILLC_INSTR_W-1:0] instruction_register,
   output logic [illc_pkg::ILLC_AC_W-1:0] accumulator_field_reg,
   output logic [illc_pkg::ILLC_DISP_W-1:0] dispatch_output_reg,
   output logic [illc_pkg::ILLC_FMA_W-1:0] fast_memory_address,
   output logic dispatch_register_load,
   // axi4-lite slave
   input wire logic [illc_pkg::ILLC_ADDR_W-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [illc_pkg::ILLC_ADDR_W-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   import illc_pkg::*;

   // held memory-control state
   illc_qual_t qual_r; // qualifiers of the last request
   logic mem_cycle_r; // memory cycle in progress
   logic dispatch_load_r; // dispatch register opens this cycle
   logic diag_strobe_r; // one-cycle diagnostic strobe
   logic diag_src_r; // strobe source: 0 work register, 1 extension
   logic [ILLC_FMA_W-1:0] fma_r; // fast memory address copy

   // gate terms
   logic load_instruction_control; // any of the three openings
   logic register_hold_term; // high keeps the latches closed
   logic instruction_latch_clock; // effective latch gate
   logic [ILLC_INSTR_W-1:0] instr_mix; // instruction register input mixer

   // bus state
   logic aw_held_r, w_held_r, awready_r, wready_r, bvalid_r, arready_r, rvalid_r; // channel flags
   logic [ILLC_ADDR_W-1:0] awaddr_r, wr_addr; // held and effective write address
   logic [31:0] wdata_r, rdata_r, wr_data, rd_word; // held, returned and effective data
   logic [3:0] wstrb_r, wr_strb; // byte strobes, held and effective
   logic [1:0] bresp_r, rresp_r; // response codes
   logic aw_take, w_take, aw_have, w_have, wr_fire, wr_hit, rd_hit; // handshake terms
   illc_status_t status_word; // software view of the held state

   // three ways to open the register: fetch during memory cycle, condition, strobe
   always_comb
   begin
      load_instruction_control = (mem_cycle_r & qual_r.fetch)
         | load_instruction_condition
         | diag_strobe_r;
      register_hold_term = ~load_instruction_control;
      // clock phase ored with the inverted control; sampled on the clock edge it is the enable
      instruction_latch_clock = ~register_hold_term;
   end

   // input mixer; adder is the default path, cache only while memory transfer is flagged
   always_comb
   begin
      if (diag_strobe_r)
         instr_mix = diag_src_r ? work_extension : work_register;
      else if (memory_transfer_clock_select)
         instr_mix = cache_data;
      else
         // adder passing a or b brings work register or fast memory here
         instr_mix = adder_out;
   end

   // instruction register: holds while closed, follows the mixer while open
   illc_gated_latch #(
      .W(ILLC_INSTR_W)
   ) u_instr (
      .clk(clk),
      .reset_n(reset_n),
      .open(instruction_latch_clock),
      .d(instr_mix),
      .q(instruction_register)
   );

   // accumulator field opens together with the instruction register
   illc_gated_latch #(
      .W(ILLC_AC_W)
   ) u_ac (
      .clk(clk),
      .reset_n(reset_n),
      .open(instruction_latch_clock),
      .d(instr_mix[ILLC_AC_LSB +: ILLC_AC_W]),
      .q(accumulator_field_reg)
   );

   // dispatch output register opens the clock after a condition load of the instruction closes
   illc_gated_latch #(
      .W(ILLC_DISP_W)
   ) u_disp (
      .clk(clk),
      .reset_n(reset_n),
      .open(dispatch_load_r),
      .d(dispatch_ram_data),
      .q(dispatch_output_reg)
   );

   // condition load arms the dispatch register load for the next clock
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         dispatch_load_r <= 1'b0;
      else
         dispatch_load_r <= load_instruction_condition;
   end

   assign dispatch_register_load = dispatch_load_r;

   // request qualifiers captured with the address register, held until the next request
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         qual_r <= '0;
      else if (address_load)
         qual_r <= request_qualifiers;
   end

   // memory cycle flag; a new start wins over a same-cycle transfer
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         mem_cycle_r <= 1'b0;
      else if (memory_cycle_start)
         mem_cycle_r <= 1'b1;
      else if (memory_box_transfer | fast_memory_transfer)
         mem_cycle_r <= 1'b0;
   end

   // fast memory addressed from the low virtual address bits
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         fma_r <= ILLC_FMA_RESET;
      else
         fma_r <= virtual_address_low;
   end

   assign fast_memory_address = fma_r;

   // write address and data may arrive in either order; hold each until both are here
   always_comb
   begin
      aw_take = s_axi_awvalid & awready_r;
      w_take = s_axi_wvalid & wready_r;
      aw_have = aw_held_r | aw_take;
      w_have = w_held_r | w_take;
      wr_fire = aw_have & w_have & ~bvalid_r;
      wr_addr = aw_held_r ? awaddr_r : s_axi_awaddr;
      wr_data = w_held_r ? wdata_r : s_axi_wdata;
      wr_strb = w_held_r ? wstrb_r : s_axi_wstrb;
      wr_hit = (wr_addr == ILLC_OFS_CONTROL);
   end

   // write channel bookkeeping; ready drops while a beat waits or a response is pending
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         aw_held_r <= 1'b0;
         w_held_r <= 1'b0;
         awaddr_r <= '0;
         wdata_r <= '0;
         wstrb_r <= '0;
         awready_r <= 1'b0;
         wready_r <= 1'b0;
         bvalid_r <= 1'b0;
         bresp_r <= ILLC_RESP_OKAY;
      end
      else
      begin
         if (aw_take)
            awaddr_r <= s_axi_awaddr;
         if (w_take)
         begin
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
         end
         aw_held_r <= aw_have & ~wr_fire;
         w_held_r <= w_have & ~wr_fire;
         if (wr_fire)
         begin
            bvalid_r <= 1'b1;
            // status and dispatch words are read-only, so writes there are refused
            bresp_r <= wr_hit ? ILLC_RESP_OKAY : ILLC_RESP_SLVERR;
         end
         else if (s_axi_bready)
            bvalid_r <= 1'b0;
         awready_r <= ~(aw_have & ~wr_fire) & ~(wr_fire | (bvalid_r & ~s_axi_bready));
         wready_r <= ~(w_have & ~wr_fire) & ~(wr_fire | (bvalid_r & ~s_axi_bready));
      end
   end

   // control register: strobe bit is write-one pulse, source bit is stored
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         diag_strobe_r <= ILLC_CTL_RESET[ILLC_CTL_STROBE_BIT];
         diag_src_r <= ILLC_CTL_RESET[ILLC_CTL_SRC_BIT];
      end
      else if (wr_fire & wr_hit & wr_strb[0])
      begin
         diag_strobe_r <= wr_data[ILLC_CTL_STROBE_BIT];
         diag_src_r <= wr_data[ILLC_CTL_SRC_BIT];
      end
      else
      begin
         // self-clearing so one write gives exactly one load
         diag_strobe_r <= 1'b0;
      end
   end

   // read mux over the three words; unmapped reads answer zero with an error
   always_comb
   begin
      status_word = '0;
      status_word.instruction = instruction_register;
      status_word.accumulator_field = accumulator_field_reg;
      status_word.mem_cycle = mem_cycle_r;
      status_word.fetch_qualifier = qual_r.fetch;
      status_word.read_qualifier = qual_r.read;
      rd_hit = 1'b1;
      unique case (s_axi_araddr)
         ILLC_OFS_CONTROL: rd_word = {30'h0000_0000, diag_src_r, 1'b0}; // strobe bit reads zero
         ILLC_OFS_STATUS: rd_word = status_word;
         ILLC_OFS_DISPATCH: rd_word = {17'h0_0000, dispatch_output_reg};
         default:
         begin
            rd_word = 32'h0000_0000;
            rd_hit = 1'b0;
         end
      endcase
   end

   // read channel: one read at a time, data the cycle after the address is taken
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         arready_r <= 1'b0;
         rvalid_r <= 1'b0;
         rdata_r <= 32'h0000_0000;
         rresp_r <= ILLC_RESP_OKAY;
      end
      else if (s_axi_arvalid & arready_r)
      begin
         arready_r <= 1'b0;
         rvalid_r <= 1'b1;
         rdata_r <= rd_word;
         rresp_r <= rd_hit ? ILLC_RESP_OKAY : ILLC_RESP_SLVERR;
      end
      else if (rvalid_r & s_axi_rready)
      begin
         rvalid_r <= 1'b0;
         arready_r <= 1'b1;
      end
      else if (!rvalid_r)
         arready_r <= 1'b1;
   end

   assign s_axi_awready = awready_r;
   assign s_axi_wready = wready_r;
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;
   assign s_axi_arready = arready_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata = rdata_r;
   assign s_axi_rresp = rresp_r;

   // checks on the load sequence
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);

   sequence s_cond_open;
      load_instruction_condition && !diag_strobe_r && !memory_transfer_clock_select;
   endsequence

   sequence s_dispatch_follow;
      dispatch_load_r ##1 (dispatch_output_reg == $past(dispatch_ram_data));
   endsequence

   a_mem_cycle_set: assert property (memory_cycle_start |=> mem_cycle_r)
      else $error("memory cycle flag not set by start");
   a_mem_cycle_clear: assert property (
      (!memory_cycle_start && (memory_box_transfer || fast_memory_transfer)) |=> !mem_cycle_r)
      else $error("memory cycle flag not cleared by transfer");
   a_qual_capture: assert property (address_load |=> qual_r == $past(request_qualifiers))
      else $error("qualifiers not captured with address");
   a_qual_hold_stable: assert property (!address_load |=> $stable(qual_r))
      else $error("qualifiers changed without request");
   a_fetch_opens_latch: assert property (
      (mem_cycle_r && qual_r.fetch && !diag_strobe_r) |=> instruction_register == $past(instr_mix))
      else $error("fetch in memory cycle did not load instruction");
   a_cond_loads_adder: assert property (s_cond_open |=> instruction_register == $past(adder_out))
      else $error("condition load did not take adder in one cycle");
   a_cache_select_path: assert property (
      (load_instruction_condition && memory_transfer_clock_select && !diag_strobe_r)
      |=> instruction_register == $past(cache_data))
      else $error("cache lines not selected on memory transfer");
   a_instr_hold_closed: assert property (!instruction_latch_clock |=> $stable(instruction_register))
      else $error("instruction register changed while closed");
   a_dispatch_after_load: assert property (s_cond_open |=> s_dispatch_follow)
      else $error("dispatch register did not follow instruction load");
   a_ac_field_load: assert property (
      instruction_latch_clock |=> accumulator_field_reg == instruction_register[3:0])
      else $error("accumulator field out of step");
   a_diag_strobe_src: assert property (
      diag_strobe_r |=> instruction_register == ($past(diag_src_r) ? $past(work_extension) : $past(work_register)))
      else $error("diagnostic strobe loaded wrong source");
   a_fast_address_copy: assert property (##1 fast_memory_address == $past(virtual_address_low))
      else $error("fast memory address not following address bits");
endmodule

// >>> verilog/illc_pkg.sv
// shared constants, register map and carrier types of the instruction latch load control
package illc_pkg;
   // datapath widths
   localparam int ILLC_INSTR_W = 13;
   localparam int ILLC_AC_W = 4;
   localparam int ILLC_DISP_W = 15;
   localparam int ILLC_DADR_W = 9;
   localparam int ILLC_FMA_W = 4;
   // field positions inside the 13-bit instruction (lsb index 0 is instruction bit 12)
   localparam int ILLC_AC_LSB = 0;
   localparam int ILLC_DADR_LSB = 4;
   // bus side
   localparam int ILLC_ADDR_W = 8;
   localparam logic [7:0] ILLC_OFS_CONTROL = 8'h00;
   localparam logic [7:0] ILLC_OFS_STATUS = 8'h04;
   localparam logic [7:0] ILLC_OFS_DISPATCH = 8'h08;
   // control register fields
   localparam int ILLC_CTL_STROBE_BIT = 0;
   localparam int ILLC_CTL_SRC_BIT = 1;
   localparam logic [31:0] ILLC_CTL_RESET = 32'h0000_0000;
   // bus responses
   localparam logic [1:0] ILLC_RESP_OKAY = 2'h0;
   localparam logic [1:0] ILLC_RESP_SLVERR = 2'h2;
   // reset values of held state
   localparam logic [12:0] ILLC_INSTR_RESET = 13'h0000;
   localparam logic [3:0] ILLC_FMA_RESET = 4'h0;

   // status word as software sees it
   typedef struct packed {
      logic [4:0] zero_hi;
      logic read_qualifier;
      logic fetch_qualifier;
      logic mem_cycle;
      logic [3:0] zero_mid;
      logic [3:0] accumulator_field;
      logic [2:0] zero_lo;
      logic [12:0] instruction;
   } illc_status_t;

   // memory-control qualifiers that travel together
   typedef struct packed {
      logic fetch;
      logic read;
   } illc_qual_t;
endpackage
